// ==== qp_defs.svh ====
`ifndef QP_DEFS_SVH
`define QP_DEFS_SVH

// organisation select: 1 gives 1M x 36, 0 gives 2M x 18
`define QP_ORG_X36      1'b1
`define QP_LANE_W       9
`define QP_DW           ((`QP_ORG_X36) ? 36 : 18)
`define QP_LANES        ((`QP_ORG_X36) ? 4 : 2)
// one location holds a two-beat pair, so the bus is one bit short of the word count
`define QP_AW           ((`QP_ORG_X36) ? 19 : 20)

// read latency in link half-cycles, loop active and loop bypassed
`define QP_LAT_DLL      5
`define QP_LAT_BYP      2
`define QP_PIPE_N       5

// sampling clock period in ns
`define QP_CLK_NS       50

`endif

// ==== qp_pkg.sv ====
`include "qp_defs.svh"

package qp_pkg;

    typedef logic [`QP_DW-1:0]      qp_beat_t;
    typedef logic [`QP_LANES-1:0]   qp_lanes_t;
    typedef logic [`QP_AW-1:0]      qp_addr_t;
    typedef logic [2*`QP_DW-1:0]    qp_pair_t;
    typedef logic [2*`QP_LANES-1:0] qp_pair_lanes_t;

    // write path: waiting for beat one and the write address
    typedef enum logic [1:0] {
        QP_WR_IDLE  = 2'h1,
        QP_WR_BEAT1 = 2'h2
    } qp_wr_state_t;

    // one read in flight
    typedef struct packed {
        logic     v;
        qp_pair_t d;
    } qp_slot_t;

    // everything sampled from the pins
    typedef struct packed {
        logic      k_true;
        logic      k_inv;
        logic      fetch_n;
        logic      store_n;
        logic      loop_n;
        qp_addr_t  loc;
        qp_beat_t  wd;
        qp_lanes_t lanes_n;
    } qp_pins_t;

endpackage

// ==== qp_mem_if.sv ====
`timescale 1ns/1ps

interface qp_mem_if;
    import qp_pkg::*;

    logic           we;
    qp_addr_t       waddr;
    qp_pair_t       wdata;
    qp_pair_lanes_t wlane;
    logic           re;
    qp_addr_t       raddr;
    qp_pair_t       rdata;

    modport ctrl  (output we, waddr, wdata, wlane, re, raddr, input rdata);
    modport store (input we, waddr, wdata, wlane, re, raddr, output rdata);
endinterface

// ==== qp_mem.sv ====
`timescale 1ns/1ps
`include "qp_defs.svh"

module qp_mem (
    input wire logic ref_clk, // sampling clock
    input wire logic rst_n,   // async reset, active low
    qp_mem_if.store  bus      // array port
);
    import qp_pkg::*;

    qp_pair_t store_q [0:(1<<`QP_AW)-1];
    qp_pair_t rdata_r;

    assign bus.rdata = rdata_r;

    // lane-masked write, each 9-bit lane on its own enable
    always_ff @(posedge ref_clk) begin
        if (bus.we) begin
            for (int i = 0; i < 2*`QP_LANES; i++) begin
                if (bus.wlane[i]) begin
                    store_q[bus.waddr][i*`QP_LANE_W +: `QP_LANE_W] <=
                        bus.wdata[i*`QP_LANE_W +: `QP_LANE_W];
                end
            end
        end
    end

    // read data comes from a register, one cycle after the request
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (bus.re) begin
            rdata_r <= store_q[bus.raddr];
        end
    end
endmodule

// ==== qp_sram_port.sv ====
`timescale 1ns/1ps
`include "qp_defs.svh"

// Notes on behaviour
// - read and write ports run concurrently
// - every access moves exactly two beats
// - read and write addresses alternate edges
// - true edge takes read address, selects, beat0
// - inverse edge takes write address, beat1
// - lane enables per beat mask bytes
// - write beat0 buffered ahead of address
// - read data two and half cycles later with loop active
// - beat0 on inverse edge, beat1 true edge with loop active; beat0 true edge, beat1 inverse edge with loop bypassed
// - echo strobes move with read data
// - organisation 1M x 36 or 2M x 18
// - store select low starts a write
// - fetch select low starts a read
// - valid flag aligned with echo strobes
// - loop bypass low gives one-cycle latency
module qp_sram_port (
    input  wire logic                   ref_clk,          // 20 MHz sampling clock
    input  wire logic                   rst_n,            // async reset, active low
    input  wire logic                   k_true,           // primary strobe
    input  wire logic                   k_inv,            // complementary strobe
    input  wire logic                   fetch_sel_n,      // read select, low active
    input  wire logic                   store_sel_n,      // write select, low active
    input  wire logic                   loop_bypass_n,    // low bypasses the loop
    input  wire qp_pkg::qp_addr_t       location_bus,     // read / write address
    input  wire qp_pkg::qp_beat_t       write_data,       // write beat
    input  wire qp_pkg::qp_lanes_t      lane_enable_n,    // lane enables, low active
    output qp_pkg::qp_beat_t            read_data,        // read beat
    output logic                        echo_strobe_true, // echo strobe
    output logic                        echo_strobe_inv,  // inverted echo strobe
    output logic                        output_valid_flag // read data valid
);
    import qp_pkg::*;

    qp_mem_if mem_bus ();

    qp_mem u_mem (  // array and buses sized by the organisation
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .bus     (mem_bus.store)
    );

    // pin synchroniser, two stages; stage one feeds only stage two
    qp_pins_t pin_s1_r, pin_s2_r;
    logic     kt_last_r, ki_last_r;
    qp_pins_t pin_now;

    assign pin_now = '{k_true: k_true, k_inv: k_inv, fetch_n: fetch_sel_n,
                       store_n: store_sel_n, loop_n: loop_bypass_n,
                       loc: location_bus, wd: write_data, lanes_n: lane_enable_n};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r  <= '0;
            pin_s2_r  <= '0;
            kt_last_r <= 1'b0;
            ki_last_r <= 1'b0;
        end else begin
            pin_s1_r  <= pin_now;
            pin_s2_r  <= pin_s1_r;
            kt_last_r <= pin_s2_r.k_true;
            ki_last_r <= pin_s2_r.k_inv;
        end
    end

    // data and strobes share the same delay, so edges still frame the data
    logic     k_tick, ki_tick, tick, dll_on, rd_take;
    qp_addr_t loc_s;
    assign k_tick  = pin_s2_r.k_true & ~kt_last_r;
    assign ki_tick = pin_s2_r.k_inv & ~ki_last_r;
    assign tick    = k_tick | ki_tick;
    assign dll_on  = pin_s2_r.loop_n;
    assign loc_s   = pin_s2_r.loc;
    assign rd_take = k_tick & ~pin_s2_r.fetch_n;

    // write path state
    qp_wr_state_t   wr_state_r, wr_state_nxt;
    qp_beat_t       wr_d0_r, wr_d0_nxt;
    qp_lanes_t      wr_l0_r, wr_l0_nxt;
    logic           buf_v_r, buf_v_nxt;
    qp_addr_t       buf_addr_r, buf_addr_nxt;
    qp_pair_t       buf_d_r, buf_d_nxt;
    qp_pair_lanes_t buf_l_r, buf_l_nxt;
    logic           mem_we_r, mem_we_nxt;
    qp_addr_t       mem_waddr_r, mem_waddr_nxt;
    qp_pair_t       mem_wdata_r, mem_wdata_nxt;
    qp_pair_lanes_t mem_wlane_r, mem_wlane_nxt;

    // late write: the buffer holds the last write until the next one retires it or a reset drops it
    always_comb begin
        wr_state_nxt  = wr_state_r;
        wr_d0_nxt     = wr_d0_r;
        wr_l0_nxt     = wr_l0_r;
        buf_v_nxt     = buf_v_r;
        buf_addr_nxt  = buf_addr_r;
        buf_d_nxt     = buf_d_r;
        buf_l_nxt     = buf_l_r;
        mem_we_nxt    = 1'b0;
        mem_waddr_nxt = mem_waddr_r;
        mem_wdata_nxt = mem_wdata_r;
        mem_wlane_nxt = mem_wlane_r;
        case (wr_state_r)
            QP_WR_IDLE: begin
                if (k_tick && !pin_s2_r.store_n) begin
                    wr_state_nxt = QP_WR_BEAT1;
                    wr_d0_nxt    = pin_s2_r.wd;
                    wr_l0_nxt    = ~pin_s2_r.lanes_n;
                end
            end
            QP_WR_BEAT1: begin
                if (ki_tick) begin
                    if (buf_v_r) begin
                        mem_we_nxt    = 1'b1;
                        mem_waddr_nxt = buf_addr_r;
                        mem_wdata_nxt = buf_d_r;
                        mem_wlane_nxt = buf_l_r;
                    end
                    buf_v_nxt    = 1'b1;
                    buf_addr_nxt = loc_s;
                    buf_d_nxt    = {pin_s2_r.wd, wr_d0_r};
                    buf_l_nxt    = {~pin_s2_r.lanes_n, wr_l0_r};
                    wr_state_nxt = QP_WR_IDLE;
                end
            end
            default: wr_state_nxt = QP_WR_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_r  <= QP_WR_IDLE;
            wr_d0_r     <= '0;
            wr_l0_r     <= '0;
            buf_v_r     <= 1'b0;
            buf_addr_r  <= '0;
            buf_d_r     <= '0;
            buf_l_r     <= '0;
            mem_we_r    <= 1'b0;
            mem_waddr_r <= '0;
            mem_wdata_r <= '0;
            mem_wlane_r <= '0;
        end else begin
            wr_state_r  <= wr_state_nxt;
            wr_d0_r     <= wr_d0_nxt;
            wr_l0_r     <= wr_l0_nxt;
            buf_v_r     <= buf_v_nxt;
            buf_addr_r  <= buf_addr_nxt;
            buf_d_r     <= buf_d_nxt;
            buf_l_r     <= buf_l_nxt;
            mem_we_r    <= mem_we_nxt;
            mem_waddr_r <= mem_waddr_nxt;
            mem_wdata_r <= mem_wdata_nxt;
            mem_wlane_r <= mem_wlane_nxt;
        end
    end

    // read fetch, merge with the buffer, then wait in the latency pipe
    logic     mem_re_r, mem_re_nxt, land_r;
    qp_addr_t mem_raddr_r, mem_raddr_nxt;
    qp_slot_t fresh_r, fresh_nxt;
    qp_slot_t pipe_r [0:`QP_PIPE_N-1];
    qp_slot_t pipe_nxt [0:`QP_PIPE_N-1];

    always_comb begin
        mem_re_nxt    = rd_take;
        mem_raddr_nxt = rd_take ? loc_s : mem_raddr_r;
        fresh_nxt     = fresh_r;
        if (tick) begin
            fresh_nxt.v = 1'b0;
        end
        if (land_r) begin
            fresh_nxt.v = 1'b1;
            fresh_nxt.d = mem_bus.rdata;
            for (int i = 0; i < 2*`QP_LANES; i++) begin
                if (buf_v_r && buf_l_r[i] && buf_addr_r == mem_raddr_r) begin
                    fresh_nxt.d[i*`QP_LANE_W +: `QP_LANE_W] =
                        buf_d_r[i*`QP_LANE_W +: `QP_LANE_W];
                end
            end
        end
        // one shift per link half-cycle keeps latency counted in edges
        for (int i = 0; i < `QP_PIPE_N; i++) begin
            pipe_nxt[i] = pipe_r[i];
        end
        if (tick) begin
            pipe_nxt[0] = fresh_r;
            for (int i = 1; i < `QP_PIPE_N; i++) begin
                pipe_nxt[i] = pipe_r[i-1];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_re_r    <= 1'b0;
            mem_raddr_r <= '0;
            land_r      <= 1'b0;
            fresh_r     <= '0;
            for (int i = 0; i < `QP_PIPE_N; i++) begin
                pipe_r[i] <= '0;
            end
        end else begin
            mem_re_r    <= mem_re_nxt;
            mem_raddr_r <= mem_raddr_nxt;
            land_r      <= mem_re_r;
            fresh_r     <= fresh_nxt;
            for (int i = 0; i < `QP_PIPE_N; i++) begin
                pipe_r[i] <= pipe_nxt[i];
            end
        end
    end

    assign mem_bus.we    = mem_we_r;
    assign mem_bus.waddr = mem_waddr_r;
    assign mem_bus.wdata = mem_wdata_r;
    assign mem_bus.wlane = mem_wlane_r;
    assign mem_bus.re    = mem_re_r;
    assign mem_bus.raddr = mem_raddr_r;

    // output stage; taps chosen by loop mode
    qp_slot_t tap0, tap1;
    qp_beat_t read_data_r, read_data_nxt;
    logic     echo_true_r, echo_true_nxt, echo_inv_r, echo_inv_nxt;
    logic     valid_r, valid_nxt;

    assign tap0 = dll_on ? pipe_r[`QP_LAT_DLL-2] : pipe_r[`QP_LAT_BYP-2];
    assign tap1 = dll_on ? pipe_r[`QP_LAT_DLL-1] : pipe_r[`QP_LAT_BYP-1];

    always_comb begin
        read_data_nxt = read_data_r;
        echo_true_nxt = echo_true_r;
        echo_inv_nxt  = echo_inv_r;
        valid_nxt     = valid_r;
        if (tick) begin
            // echo strobes run free and share the data's edge
            echo_true_nxt = dll_on ? ki_tick : k_tick;
            echo_inv_nxt  = dll_on ? k_tick : ki_tick;
            valid_nxt     = tap0.v | tap1.v;
            if (tap0.v) begin
                read_data_nxt = tap0.d[`QP_DW-1:0];
            end else if (tap1.v) begin
                read_data_nxt = tap1.d[2*`QP_DW-1:`QP_DW];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            read_data_r <= '0;
            echo_true_r <= 1'b0;
            echo_inv_r  <= 1'b1;
            valid_r     <= 1'b0;
        end else begin
            read_data_r <= read_data_nxt;
            echo_true_r <= echo_true_nxt;
            echo_inv_r  <= echo_inv_nxt;
            valid_r     <= valid_nxt;
        end
    end

    assign read_data         = read_data_r;
    assign echo_strobe_true  = echo_true_r;
    assign echo_strobe_inv   = echo_inv_r;
    assign output_valid_flag = valid_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_burst_held;
        valid_r [*7];
    endsequence

    echo_pair_a: assert property (echo_inv_r == ~echo_true_r)
        else $error("echo strobes not complementary");
    data_echo_a: assert property ($changed(read_data_r) |-> $changed(echo_true_r))
        else $error("read data moved without echo strobe");
    valid_tick_a: assert property ($changed(valid_r) |-> $past(tick))
        else $error("valid flag moved off a strobe edge");
    burst_two_a: assert property ($rose(valid_r) |-> s_burst_held)
        else $error("valid flag shorter than two beats");
    read_dll_a: assert property (rd_take && dll_on |-> ##[19:23] valid_r)
        else $error("read data late with loop active");
    read_byp_a: assert property (rd_take && !dll_on |-> ##[7:11] valid_r)
        else $error("read data late with loop bypassed");
    no_access_a: assert property (k_tick && pin_s2_r.fetch_n |=> !mem_re_r)
        else $error("array read without read select");
    wr_commit_a: assert property (mem_we_r |-> $past(ki_tick && wr_state_r == QP_WR_BEAT1))
        else $error("array write outside a write cycle");
    wr_addr_a: assert property (ki_tick && wr_state_r == QP_WR_BEAT1
                                |=> buf_v_r && buf_addr_r == $past(loc_s))
        else $error("write address not taken on inverse strobe");
endmodule

// ==== qp_ctrl_model.sv ====
`timescale 1ns/1ps
`include "qp_defs.svh"

// controller side: makes the strobe pair, issues commands, collects beats
module qp_ctrl_model (
    input  wire logic              ref_clk,           // sampling clock
    output logic                   k_true,            // primary strobe
    output logic                   k_inv,             // complementary strobe
    output logic                   fetch_sel_n,       // read select
    output logic                   store_sel_n,       // write select
    output qp_pkg::qp_addr_t       location_bus,      // address pins
    output qp_pkg::qp_beat_t       write_data,        // write beat
    output qp_pkg::qp_lanes_t      lane_enable_n,     // lane enables
    input  wire qp_pkg::qp_beat_t  read_data,         // read beat
    input  wire logic              echo_strobe_true,  // echo strobe
    input  wire logic              output_valid_flag  // read valid
);
    import qp_pkg::*;

    qp_beat_t rq [$];
    logic     echo_q = 1'b0;
    logic     vld_q  = 1'b0;
    int       cyc    = 0;
    int       rd_cyc = 0;
    int       lat    = 0;

    // idle pins: strobes low so reset release sees no edge
    initial begin
        k_true        = 1'b0;
        k_inv         = 1'b0;
        fetch_sel_n   = 1'b1;
        store_sel_n   = 1'b1;
        location_bus  = '0;
        write_data    = '0;
        lane_enable_n = '1;
    end

    always @(posedge ref_clk) cyc <= cyc + 1;

    // a beat counts only when the echo moves with valid high
    always @(negedge ref_clk) begin
        if (output_valid_flag === 1'b1 && echo_strobe_true !== echo_q) begin
            rq.push_back(read_data);
        end
        if (output_valid_flag === 1'b1 && vld_q !== 1'b1) begin
            lat <= cyc - rd_cyc;
        end
        echo_q <= echo_strobe_true;
        vld_q  <= output_valid_flag;
    end

    // one link cycle of 8 sampling clocks; data moves with its strobe edge,
    // so each value stands a whole half cycle past the edge it belongs to
    task automatic issue(input logic rd, input qp_addr_t ra, input logic wr,
                         input qp_addr_t wa, input qp_pair_t d,
                         input qp_pair_lanes_t ln);
        @(negedge ref_clk);
        k_true        = 1'b1;
        k_inv         = 1'b0;
        fetch_sel_n   = ~rd;
        store_sel_n   = ~wr;
        location_bus  = ra;
        write_data    = d[`QP_DW-1:0];
        lane_enable_n = ln[`QP_LANES-1:0];
        if (rd) rd_cyc = cyc;
        repeat (4) @(negedge ref_clk);
        k_true        = 1'b0;
        k_inv         = 1'b1;
        location_bus  = wa;
        write_data    = d[2*`QP_DW-1:`QP_DW];
        lane_enable_n = ln[2*`QP_LANES-1:`QP_LANES];
        repeat (3) @(negedge ref_clk);
    endtask

    // stop the strobes low, e.g. ahead of a reset
    task automatic park;
        @(negedge ref_clk);
        k_inv = 1'b0;
    endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "qp_defs.svh"

module tb_top;
    import qp_pkg::*;

    typedef struct {
        logic           rd;
        qp_addr_t       ra;
        logic           wr;
        qp_addr_t       wa;
        qp_pair_t       d;
        qp_pair_lanes_t ln;
    } qp_row_t;

    logic           ref_clk;
    logic           rst_n;
    logic           k_true;
    logic           k_inv;
    logic           fetch_sel_n;
    logic           store_sel_n;
    logic           loop_bypass_n;
    qp_addr_t       location_bus;
    qp_beat_t       write_data;
    qp_lanes_t      lane_enable_n;
    qp_beat_t       read_data;
    logic           echo_strobe_true;
    logic           echo_strobe_inv;
    logic           output_valid_flag;
    int             num_errors;
    int             n_compared;
    qp_beat_t       eq [$];
    qp_pair_t       mem [qp_addr_t];
    qp_row_t        rows [8];
    qp_row_t        r;

    qp_sram_port u_qp_sram_port (
        .ref_clk(ref_clk), .rst_n(rst_n), .k_true(k_true), .k_inv(k_inv),
        .fetch_sel_n(fetch_sel_n), .store_sel_n(store_sel_n),
        .loop_bypass_n(loop_bypass_n), .location_bus(location_bus),
        .write_data(write_data), .lane_enable_n(lane_enable_n),
        .read_data(read_data), .echo_strobe_true(echo_strobe_true),
        .echo_strobe_inv(echo_strobe_inv), .output_valid_flag(output_valid_flag));

    qp_ctrl_model u_qp_ctrl_model (
        .ref_clk(ref_clk), .k_true(k_true), .k_inv(k_inv),
        .fetch_sel_n(fetch_sel_n), .store_sel_n(store_sel_n),
        .location_bus(location_bus), .write_data(write_data),
        .lane_enable_n(lane_enable_n), .read_data(read_data),
        .echo_strobe_true(echo_strobe_true), .output_valid_flag(output_valid_flag));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // every lane distinct so swapped lanes or beats show up
    function automatic qp_pair_t pat(input logic [4:0] k);
        for (int i = 0; i < 2*`QP_LANES; i++) pat[i*`QP_LANE_W +: `QP_LANE_W] = {k, 4'(i)};
    endfunction

    function automatic qp_pair_t merge(input qp_pair_t o, input qp_pair_t d,
                                       input qp_pair_lanes_t ln);
        merge = o;
        for (int i = 0; i < 2*`QP_LANES; i++) begin
            if (!ln[i]) merge[i*`QP_LANE_W +: `QP_LANE_W] = d[i*`QP_LANE_W +: `QP_LANE_W];
        end
    endfunction

    task automatic chk_beat(input qp_beat_t g, input qp_beat_t e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t: beat got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t: flag got %b exp %b", $time, g, e);
        end
    endtask

    task automatic chk_int(input int g, input int lo, input int hi);
        n_compared++;
        if (g < lo || g > hi) begin
            num_errors++;
            $display("ERROR %0t: count %0d not in %0d..%0d", $time, g, lo, hi);
        end
    endtask

    task automatic report_and_stop;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // reset with checks while held; release well before the first strobe
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        chk_beat(read_data, '0);
        chk_bit(echo_strobe_true, 1'b0);
        chk_bit(echo_strobe_inv, 1'b1);
        chk_bit(output_valid_flag, 1'b0);
        rst_n = 1'b1;
        // just after release the valid flag must stay low and the echo strobes complementary
        @(negedge ref_clk);
        chk_bit(output_valid_flag, 1'b0);
        chk_bit(echo_strobe_inv, ~echo_strobe_true);
        repeat (4) @(negedge ref_clk);
    endtask

    // strobes keep running idle until every expected beat is in, bounded
    task automatic drain;
        int n;
        n = 0;
        while (u_qp_ctrl_model.rq.size() < eq.size() && n < 12) begin
            u_qp_ctrl_model.issue(1'b0, '0, 1'b0, '0, '0, '1);
            n++;
        end
        repeat (2) u_qp_ctrl_model.issue(1'b0, '0, 1'b0, '0, '0, '1);
        if (u_qp_ctrl_model.rq.size() < eq.size()) begin
            num_errors++;
            $display("ERROR %0t: read beats never arrived", $time);
            report_and_stop();
        end else begin
            chk_int(u_qp_ctrl_model.rq.size(), eq.size(), eq.size());
            foreach (eq[i]) chk_beat(u_qp_ctrl_model.rq[i], eq[i]);
            eq.delete();
            u_qp_ctrl_model.rq.delete();
        end
    endtask

    // queue what the table model expects of a read, before same-cycle write
    task automatic expect_read(input qp_addr_t a);
        eq.push_back(mem[a][`QP_DW-1:0]);
        eq.push_back(mem[a][2*`QP_DW-1:`QP_DW]);
    endtask

    task automatic rd_check(input qp_addr_t a, input int lo, input int hi);
        expect_read(a);
        u_qp_ctrl_model.issue(1'b1, a, 1'b0, a, pat(5'h1F), '1);
        drain();
        chk_int(u_qp_ctrl_model.lat, lo, hi);
    endtask

    initial begin
        num_errors    = 0;
        n_compared    = 0;
        loop_bypass_n = 1'b1;
        // rd, read addr, wr, write addr, data pair, lane enables (low writes)
        rows[0] = '{1'b0, 19'h10, 1'b1, 19'h10, pat(5'h01), 8'h00};
        rows[1] = '{1'b1, 19'h10, 1'b1, 19'h11, pat(5'h02), 8'h00};
        rows[2] = '{1'b1, 19'h11, 1'b1, 19'h10, pat(5'h03), 8'h7E};
        rows[3] = '{1'b1, 19'h10, 1'b1, 19'h11, pat(5'h04), 8'h00};
        rows[4] = '{1'b1, 19'h11, 1'b1, 19'h11, pat(5'h05), 8'hF0};
        rows[5] = '{1'b0, 19'h10, 1'b0, 19'h11, pat(5'h09), 8'h00};
        rows[6] = '{1'b1, 19'h11, 1'b0, 19'h10, pat(5'h0A), 8'h00};
        rows[7] = '{1'b1, 19'h10, 1'b1, 19'h20, pat(5'h06), 8'h00};
        do_reset();
        // back to back; rows 1 to 4 and 7 read and write in the same link cycle
        foreach (rows[i]) begin
            r = rows[i];
            if (r.rd) expect_read(r.ra);
            if (r.wr) mem[r.wa] = merge(mem.exists(r.wa) ? mem[r.wa] : '0, r.d, r.ln);
            u_qp_ctrl_model.issue(r.rd, r.ra, r.wr, r.wa, r.d, r.ln);
        end
        drain();
        // second reset mid-run; the array keeps its contents
        u_qp_ctrl_model.park();
        do_reset();
        rd_check(19'h11, 21, 25);
        // loop bypassed with nothing in flight: one-cycle latency
        @(negedge ref_clk);
        loop_bypass_n = 1'b0;
        u_qp_ctrl_model.issue(1'b0, '0, 1'b0, '0, '0, '1);
        rd_check(19'h10, 9, 13);
        report_and_stop();
    end
endmodule
